// ### rtl/burst_sram_pkg.sv
// constants and types for the pipelined burst static memory port
// assumes a single 100 MHz clock and a synchronous active-high reset
`default_nettype none
package burst_sram_pkg;
    // ========================================
    // geometry
    localparam int ADDR_W = 17;
    localparam int DEPTH = 131072;
    localparam int LANES = 4;
    localparam int LANE_DATA_W = 8;
    localparam int LANE_W = 9;
    localparam int DATA_W = 32;
    localparam int WORD_W = 36;
    localparam int BURST_W = 2;

    // ========================================
    // reset values and counts
    localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;
    localparam logic [BURST_W-1:0] BEAT_RESET = 2'h0;
    localparam logic [BURST_W-1:0] BEAT_STEP = 2'h1;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
    localparam logic [LANES-1:0] PARITY_RESET = 4'h0;

    // ========================================
    // operation carried down the pipeline
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE
    } op_t;
endpackage
`default_nettype wire

// ### rtl/burst_sram_port.sv
// 128K x 36 pipelined burst static memory with no-wait read/write turnaround
// assumes all pins synchronous to clk; the output enable and sleep inputs
// are gated combinationally onto the drive enables
//
// Overview of operation
// [RULE1] back-to-back reads and writes, no wait states
// [RULE2] all synchronous inputs registered on rising edge
// [RULE3] read data launched from output registers
// [RULE4] clock hold high freezes all state
// [RULE5] one write strobe plus four byte selects
// [RULE6] drivers off during every write data phase
// [RULE7] selected when selects low, high, low
// [RULE8] sampled address picks one of 128K words
// [RULE9] low two address bits seed burst counter
// [RULE10] byte select writes its lane with strobe
// [RULE11] write starts with strobe low, hold low
// [RULE12] advance high steps the burst counter
// [RULE13] advance low loads a fresh address
// [RULE14] controller loads address after a deselect
// [RULE15] output enable low lets pins drive
// [RULE16] outputs off on writes and deselect
// [RULE17] strap picks linear or interleaved burst
// [RULE18] sleep freezes device, keeps stored data
// [RULE19] parity lines follow their lane's byte select
// [RULE20] data on pins two enabled edges later
// [RULE21] four 9-bit lanes, eight data one parity
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port (
    input wire logic clk, // 100 MHz clock
    input wire logic reset, // synchronous, active high
    input wire logic [16:0] address, // word address
    input wire logic chip_select_a_n, // select, active low
    input wire logic chip_select_b, // select, active high
    input wire logic chip_select_c_n, // select, active low
    input wire logic write_strobe_n, // write strobe, active low
    input wire logic [3:0] byte_write_sel_n, // per-lane write select, active low
    input wire logic advance_load, // 1 advance burst, 0 load address
    input wire logic clock_hold_n, // 0 lets the edge act
    input wire logic output_enable_n, // output enable, active low
    input wire logic burst_order_sel, // strap: 0 linear, 1 interleaved
    input wire logic sleep_request, // sleep, active high
    input wire logic [31:0] dataIn, // data pins as seen
    output logic [31:0] dataOut, // data pins driven value
    output logic dataOutEn, // data pins drive enable
    input wire logic [3:0] parity_io_in, // parity pins as seen
    output logic [3:0] parity_io_out, // parity pins driven value
    output logic parity_io_oe // parity pins drive enable
);
    // ========================================
    // state
    logic [burst_sram_pkg::WORD_W-1:0] memArray [0:burst_sram_pkg::DEPTH-1];
    burst_sram_pkg::op_t lastOp_reg;
    burst_sram_pkg::op_t s1Op_reg;
    burst_sram_pkg::op_t s2Op_reg;
    logic [burst_sram_pkg::ADDR_W-1:0] baseAddr_reg;
    logic [burst_sram_pkg::BURST_W-1:0] beat_reg;
    logic [burst_sram_pkg::ADDR_W-1:0] s1Addr_reg;
    logic [burst_sram_pkg::ADDR_W-1:0] s2Addr_reg;
    logic [burst_sram_pkg::LANES-1:0] s1Lane_reg;
    logic [burst_sram_pkg::LANES-1:0] s2Lane_reg;
    logic [burst_sram_pkg::DATA_W-1:0] dataOut_reg;
    logic [burst_sram_pkg::LANES-1:0] parityOut_reg;
    logic driveEn_reg;
    logic interleave_reg;

    // ========================================
    // edge qualification and selection decode
    wire logic edgeEn;
    wire logic selected;
    wire logic loadNow;
    wire logic writeReq;
    assign edgeEn = ~clock_hold_n ? ~sleep_request : 1'b0; // RULE4 RULE18
    assign selected = ~chip_select_a_n & chip_select_b & ~chip_select_c_n; // RULE7
    assign loadNow = ~advance_load; // RULE13
    assign writeReq = ~write_strobe_n; // RULE5 RULE11

    // ========================================
    // burst address generation
    wire logic [burst_sram_pkg::BURST_W-1:0] beat_next;
    wire logic [burst_sram_pkg::BURST_W-1:0] lowLinear;
    wire logic [burst_sram_pkg::BURST_W-1:0] lowInter;
    wire logic [burst_sram_pkg::BURST_W-1:0] lowBurst;
    wire logic [burst_sram_pkg::ADDR_W-1:0] advAddr;
    assign beat_next = beat_reg + burst_sram_pkg::BEAT_STEP; // RULE12
    assign lowLinear = baseAddr_reg[burst_sram_pkg::BURST_W-1:0] + beat_next;
    assign lowInter = baseAddr_reg[burst_sram_pkg::BURST_W-1:0] ^ beat_next;
    assign lowBurst = interleave_reg ? lowInter : lowLinear; // RULE17
    assign advAddr = {baseAddr_reg[burst_sram_pkg::ADDR_W-1:burst_sram_pkg::BURST_W],
                      lowBurst}; // RULE9

    // ========================================
    // next operation: load decodes the pins, advance repeats the last kind
    burst_sram_pkg::op_t loadOp;
    burst_sram_pkg::op_t newOp;
    wire logic [burst_sram_pkg::ADDR_W-1:0] newAddr;
    wire logic [burst_sram_pkg::LANES-1:0] newLane;
    assign loadOp = !selected ? burst_sram_pkg::OP_IDLE
                  : (writeReq ? burst_sram_pkg::OP_WRITE : burst_sram_pkg::OP_READ);
    // an advance from a deselect stays deselected; the controller reloads
    assign newOp = loadNow ? loadOp : lastOp_reg; // RULE12 RULE13 RULE14
    assign newAddr = loadNow ? address : advAddr; // RULE8
    assign newLane = ~byte_write_sel_n; // RULE10

    // ========================================
    // read path with bypass of the write committing on the same edge
    wire logic [burst_sram_pkg::WORD_W-1:0] arrayWord;
    wire logic [burst_sram_pkg::WORD_W-1:0] pinWord;
    wire logic [burst_sram_pkg::WORD_W-1:0] mergedWrite;
    wire logic [burst_sram_pkg::WORD_W-1:0] readWord;
    wire logic bypassHit;
    assign arrayWord = memArray[s1Addr_reg];
    assign bypassHit = (s2Op_reg == burst_sram_pkg::OP_WRITE) && (s2Addr_reg == s1Addr_reg);
    genvar lane;
    generate
        for (lane = 0; lane < burst_sram_pkg::LANES; lane++)
        begin : g_lane
            // lane = eight data bits with its parity bit on top
            assign pinWord[lane*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
                {parity_io_in[lane], dataIn[lane*burst_sram_pkg::LANE_DATA_W +:
                                            burst_sram_pkg::LANE_DATA_W]}; // RULE21
            assign mergedWrite[lane*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
                s2Lane_reg[lane]
                ? pinWord[lane*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W]
                : memArray[s2Addr_reg][lane*burst_sram_pkg::LANE_W +:
                                       burst_sram_pkg::LANE_W]; // RULE10 RULE19
            assign readWord[lane*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
                (bypassHit && s2Lane_reg[lane])
                ? pinWord[lane*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W]
                : arrayWord[lane*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W]; // RULE1
        end
    endgenerate

    // split the read word back into data and parity pins
    logic [burst_sram_pkg::DATA_W-1:0] readData;
    logic [burst_sram_pkg::LANES-1:0] readParity;
    always_comb
    begin
        readData = burst_sram_pkg::DATA_RESET;
        readParity = burst_sram_pkg::PARITY_RESET;
        for (int i = 0; i < burst_sram_pkg::LANES; i++)
        begin
            readData[i*burst_sram_pkg::LANE_DATA_W +: burst_sram_pkg::LANE_DATA_W] =
                readWord[i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_DATA_W];
            readParity[i] = readWord[i*burst_sram_pkg::LANE_W + burst_sram_pkg::LANE_DATA_W];
        end
    end

    // ========================================
    // strap caught while reset is held, static afterwards
    always_ff @(posedge clk)
    begin
        if (reset)
            interleave_reg <= burst_order_sel; // RULE17
    end

    // ========================================
    // input registers and burst counter
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s1Op_reg <= burst_sram_pkg::OP_IDLE;
            lastOp_reg <= burst_sram_pkg::OP_IDLE;
            s1Addr_reg <= burst_sram_pkg::ADDR_RESET;
            s1Lane_reg <= burst_sram_pkg::PARITY_RESET;
            baseAddr_reg <= burst_sram_pkg::ADDR_RESET;
            beat_reg <= burst_sram_pkg::BEAT_RESET;
        end
        else if (edgeEn) // RULE4
        begin
            s1Op_reg <= newOp; // RULE2
            s1Addr_reg <= newAddr; // RULE2
            s1Lane_reg <= newLane; // RULE2
            lastOp_reg <= newOp;
            baseAddr_reg <= loadNow ? address : baseAddr_reg; // RULE9 RULE13
            beat_reg <= loadNow ? burst_sram_pkg::BEAT_RESET : beat_next; // RULE12
        end
    end

    // ========================================
    // second stage: holds the access whose data phase is now on the pins
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s2Op_reg <= burst_sram_pkg::OP_IDLE;
            s2Addr_reg <= burst_sram_pkg::ADDR_RESET;
            s2Lane_reg <= burst_sram_pkg::PARITY_RESET;
        end
        else if (edgeEn)
        begin
            s2Op_reg <= s1Op_reg;
            s2Addr_reg <= s1Addr_reg;
            s2Lane_reg <= s1Lane_reg;
        end
    end

    // ========================================
    // self-timed write: pins taken on the data edge, no pulse from outside
    always_ff @(posedge clk)
    begin
        if (!reset && edgeEn && s2Op_reg == burst_sram_pkg::OP_WRITE)
            memArray[s2Addr_reg] <= mergedWrite; // RULE5 RULE20
    end

    // ========================================
    // output registers; drive only for a read data phase, which also keeps
    // the pins quiet on writes, while deselected and on the first selected clock
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dataOut_reg <= burst_sram_pkg::DATA_RESET;
            parityOut_reg <= burst_sram_pkg::PARITY_RESET;
            driveEn_reg <= 1'b0;
        end
        else if (edgeEn)
        begin
            dataOut_reg <= readData; // RULE3 RULE20
            parityOut_reg <= readParity; // RULE19
            driveEn_reg <= (s1Op_reg == burst_sram_pkg::OP_READ); // RULE6 RULE16
        end
    end

    // ========================================
    // pin drivers; output enable acts without the clock so that it can
    // turn the bus round within a cycle
    assign dataOut = dataOut_reg;
    assign parity_io_out = parityOut_reg;
    assign dataOutEn = driveEn_reg & ~output_enable_n & ~sleep_request; // RULE15 RULE18
    assign parity_io_oe = driveEn_reg & ~output_enable_n & ~sleep_request; // RULE15
endmodule
`default_nettype wire

// ### dv/burst_sram_port_monitor.sv
// checker for the burst memory port, bound to its top-level ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b,
    input wire logic chip_select_c_n,
    input wire logic write_strobe_n,
    input wire logic advance_load,
    input wire logic clock_hold_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic [31:0] dataOut,
    input wire logic dataOutEn,
    input wire logic [3:0] parity_io_out,
    input wire logic parity_io_oe
);
    // ========================================
    // load decode
    wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    wire go = !clock_hold_n && !sleep_request;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence readLoad;
        go && !advance_load && sel && write_strobe_n;
    endsequence
    sequence writeLoad;
        go && !advance_load && sel && !write_strobe_n;
    endsequence
    sequence idleLoad;
        go && !advance_load && !sel;
    endsequence
    // ========================================
    // properties
    a_read_drives: assert property (
        readLoad ##1 go |=> dataOutEn || output_enable_n || sleep_request)
        else $error("read data not driven");
    a_write_quiet: assert property (writeLoad ##1 go |=> !dataOutEn)
        else $error("driven in write data phase");
    a_deselect_quiet: assert property (idleLoad ##1 go |=> !dataOutEn)
        else $error("driven while deselected");
    a_oe_masks: assert property (output_enable_n |-> !dataOutEn && !parity_io_oe)
        else $error("driven with output enable high");
    a_sleep_masks: assert property (sleep_request |-> !dataOutEn)
        else $error("driven in sleep");
    a_sleep_freezes: assert property (sleep_request |=> $stable(dataOut))
        else $error("output moved in sleep");
    a_parity_lane: assert property (parity_io_oe == dataOutEn)
        else $error("parity enable differs");
    a_hold_freezes: assert property (
        clock_hold_n |=> $stable(dataOut) && $stable(parity_io_out))
        else $error("output moved on held edge");
    a_reset_clears: assert property (disable iff (1'b0) reset |=> dataOut == 32'h0 && !dataOutEn)
        else $error("output not cleared by reset");
endmodule
bind burst_sram_port burst_sram_port_monitor mon (.*);
`default_nettype wire

// ### dv/sram_ctrl_model.sv
// controller-side model: puts write data on the pins two enabled edges late
// assumes the bench says per request whether it writes and with what word
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic clock_hold_n,
    input wire logic sleep_request,
    input wire logic wrValid,
    input wire logic [35:0] wrWord,
    input wire logic [31:0] dataOut,
    input wire logic dataOutEn,
    input wire logic [3:0] parity_io_out,
    input wire logic parity_io_oe,
    output logic [31:0] dataIn,
    output logic [3:0] parity_io_in
);
    // ========================================
    // write pipeline, frozen on held edges
    logic [36:0] stage1Reg = 37'h0;
    logic [36:0] stage2Reg = 37'h0;
    logic [35:0] lastReg = 36'h0;
    logic [35:0] farDrive;
    always @(posedge clk)
    begin
        lastReg <= {parity_io_in, dataIn};
        if (!reset && !clock_hold_n && !sleep_request)
        begin
            stage1Reg <= {wrValid, wrWord};
            stage2Reg <= stage1Reg;
        end
    end
    // released pins show the inverse of their last level, never a stale copy
    assign farDrive = stage2Reg[36] ? stage2Reg[35:0] : ~lastReg;
    assign dataIn = dataOutEn ? dataOut : farDrive[31:0];
    assign parity_io_in = parity_io_oe ? parity_io_out : farDrive[35:32];
endmodule
`default_nettype wire

// ### dv/pipelined_burst_sram_port_tb.sv
// directed self-checking bench for the burst memory port
// assumes the controller model resolves the shared pins
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_port_tb;
    // ========================================
    // stimulus and pins
    localparam logic [2:0] SEL = 3'h2;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [16:0] address = 17'h0;
    logic chip_select_a_n = 1'b1, chip_select_b = 1'b0, chip_select_c_n = 1'b1;
    logic write_strobe_n = 1'b1, advance_load = 1'b0, clock_hold_n = 1'b0, wrValid = 1'b0;
    logic output_enable_n = 1'b0, burst_order_sel = 1'b0, sleep_request = 1'b0;
    logic [3:0] byte_write_sel_n = 4'hf;
    logic [35:0] wrWord = 36'h0;
    logic [31:0] dataIn, dataOut;
    logic [3:0] parity_io_in, parity_io_out;
    logic dataOutEn, parity_io_oe;
    int miscompares = 0, num_checks = 0, cycles = 0;
    burst_sram_port dut (.*);
    sram_ctrl_model partner (.*);
    initial forever #5 clk = ~clk;
    // ========================================
    // shared tasks
    task automatic drive(input logic [16:0] a, input logic adv, wr, hold,
        input logic [2:0] cs, input logic [3:0] bw, input logic [35:0] w);
        @(posedge clk);
        address <= a;
        advance_load <= adv;
        write_strobe_n <= ~wr;
        clock_hold_n <= hold;
        {chip_select_a_n, chip_select_b, chip_select_c_n} <= cs;
        byte_write_sel_n <= bw;
        wrValid <= wr;
        wrWord <= w;
    endtask
    task automatic idle(input logic hold);
        drive(17'h0, 1'b0, 1'b0, hold, 3'h6, 4'hf, 36'h0);
    endtask
    task automatic expect_pins(input logic en, input logic [35:0] w);
        #1;
        num_checks++;
        if (dataOutEn !== en || parity_io_oe !== en || (en && {parity_io_in, dataIn} !== w))
        begin
            miscompares++;
            $display("MISMATCH %0t pins %h en %b", $time, {parity_io_in, dataIn}, dataOutEn);
        end
    endtask
    function automatic logic [35:0] lanes(input logic [3:0] bwN);
        lanes = 36'h0;
        for (int i = 0; i < 4; i++)
            if (!bwN[i])
                lanes |= {4'h1 << i, 32'hff << (8 * i)};
    endfunction
    function automatic logic [35:0] word(input logic [16:0] a);
        word = {a[3:0], 15'h0, a};
    endfunction
    task automatic do_reset(input logic m);
        @(posedge clk);
        reset <= 1'b1;
        burst_order_sel <= m;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
    endtask
    // ========================================
    // scenarios
    task automatic rw_turnaround();
        logic [35:0] w = (36'h912345678 & ~lanes(4'h5)) | (36'h6abcdef01 & lanes(4'h5));
        drive(17'h00a5, 1'b0, 1'b1, 1'b0, SEL, 4'h0, 36'h912345678);
        drive(17'h00a5, 1'b0, 1'b1, 1'b0, SEL, 4'h5, 36'h6abcdef01);
        drive(17'h00a5, 1'b0, 1'b0, 1'b0, SEL, 4'h0, 36'h0);
        drive(17'h00a5, 1'b0, 1'b0, 1'b0, SEL, 4'hf, 36'h0);
        expect_pins(1'b0, 36'h0);
        idle(1'b0);
        expect_pins(1'b1, w);
        idle(1'b0);
        expect_pins(1'b1, w);
    endtask
    task automatic burst_order(input logic m);
        logic [1:0] k;
        do_reset(m);
        for (int b = 0; b < 4; b++)
            drive(17'h0104 + 17'(b), 1'b0, 1'b1, 1'b0, SEL, 4'h0, word(17'h0104 + 17'(b)));
        for (int b = 0; b < 6; b++)
        begin
            if (b < 4)
                drive(b ? 17'h1ffff : 17'h0105, b != 0, 1'b0, 1'b0, SEL, 4'hf, 36'h0);
            else
                idle(1'b0);
            k = 2'(b - 2);
            if (b >= 2)
                expect_pins(1'b1, word({15'h0041, m ? 2'h1 ^ k : 2'h1 + k}));
        end
    endtask
    task automatic hold_stall();
        drive(17'h0104, 1'b0, 1'b0, 1'b0, SEL, 4'hf, 36'h0);
        drive(17'h0106, 1'b0, 1'b0, 1'b0, SEL, 4'hf, 36'h0);
        idle(1'b1);
        expect_pins(1'b1, word(17'h0104));
        idle(1'b1);
        expect_pins(1'b1, word(17'h0104));
        idle(1'b0);
        expect_pins(1'b1, word(17'h0104));
        idle(1'b0);
        expect_pins(1'b1, word(17'h0106));
    endtask
    task automatic masked_reads();
        logic [2:0] cs[5] = '{3'h6, 3'h0, 3'h3, SEL, SEL};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            output_enable_n <= (i == 3);
            drive(17'h0104, 1'b0, 1'b0, 1'b0, cs[i], 4'hf, 36'h0);
            idle(1'b0);
            idle(1'b0);
            // sleep raised while read data stands, so only the mask can quiet the pins
            sleep_request <= (i == 4);
            expect_pins(1'b0, 36'h0);
        end
        @(posedge clk);
        output_enable_n <= 1'b0;
        sleep_request <= 1'b0;
    endtask
    // ========================================
    // run control
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // whole run is under a hundred cycles; the ceiling only catches a hang
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            final_report();
        end
    end
    initial
    begin
        do_reset(1'b0);
        rw_turnaround();
        burst_order(1'b0);
        burst_order(1'b1);
        hold_stall();
        masked_reads();
        final_report();
    end
endmodule
`default_nettype wire
